/* File: bench/dac_sink_model.sv */
// Converter-side model: takes one sample pair per clock while valid.
// Assumes the pair is registered on the rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module dac_sink_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Sample pair
    input wire logic [dds_pkg::SAMPLE_W-1:0] even_in,
    input wire logic [dds_pkg::SAMPLE_W-1:0] odd_in,
    input wire logic valid_in,
    // Capture
    output logic [31:0] pair_cnt_q,
    output logic [dds_pkg::SAMPLE_W-1:0] last_even_q,
    output logic [dds_pkg::SAMPLE_W-1:0] last_odd_q
);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pair_cnt_q <= 32'h0;
        end else if (valid_in) begin
            pair_cnt_q <= pair_cnt_q + 32'h1;
            last_even_q <= even_in;
            last_odd_q <= odd_in;
        end
    end
endmodule : dac_sink_model
`default_nettype wire

/* File: bench/dds_waveform_generator_properties.sv */
// Port checks for the synthesis core.
// Bound to every dds_waveform_generator instance.
`timescale 1ns/10ps
`default_nettype none
module dds_props (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Watched ports
    input wire logic list_clear,
    input wire logic list_wr_en,
    input wire logic list_full,
    input wire logic stop,
    input wire logic trig_pin,
    input wire logic generating,
    input wire logic dac_valid_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [9:0] cnt_q;
    // Entries written while not generating and not full
    always_ff @(posedge clock) begin
        if (!rst_n || list_clear) begin
            cnt_q <= 10'h000;
        end else if (list_wr_en && !generating && !list_full) begin
            cnt_q <= cnt_q + 10'h001;
        end
    end
    property p_stop_ends; stop && generating |=> !generating; endproperty
    a_stop_ends: assert property (p_stop_ends) else $error("ran past stop");
    property p_free_hold; generating && !stop && cnt_q == 10'h000 |=> generating; endproperty
    a_free_hold: assert property (p_free_hold) else $error("free run ended");
    property p_trig; $rose(trig_pin) && !generating && !stop |-> ##[1:8] generating; endproperty
    a_trig: assert property (p_trig) else $error("no start after trigger");
    property p_vrise; $rose(dac_valid_q) |-> $past(generating, 29); endproperty
    a_vrise: assert property (p_vrise) else $error("valid rose off latency");
    property p_vfall; $fell(dac_valid_q) |-> !$past(generating, 29); endproperty
    a_vfall: assert property (p_vfall) else $error("valid fell off latency");
    property p_full; list_full == (cnt_q == 10'h200); endproperty
    a_full: assert property (p_full) else $error("full flag wrong");
    property p_frise; $rose(list_full) |-> $past(list_wr_en) && !$past(list_clear); endproperty
    a_frise: assert property (p_frise) else $error("full without write");
    property p_clear; list_clear |=> !list_full; endproperty
    a_clear: assert property (p_clear) else $error("clear left list full");
endmodule : dds_props
bind dds_waveform_generator dds_props u_props (
    .clock(clock), .rst_n(rst_n), .list_clear(list_clear), .list_wr_en(list_wr_en),
    .list_full(list_full), .stop(stop), .trig_pin(trig_pin), .generating(generating),
    .dac_valid_q(dac_valid_q)
);
`default_nettype wire

/* File: bench/dds_waveform_generator_test.sv */
// Self-checking bench for the synthesis core.
// Assumes the converter model and the bound checker are compiled before.
`timescale 1ns/10ps
`default_nettype none
`define CHECK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module dds_waveform_generator_test;
    logic clock = 1'b0, rst_n = 1'b0, lut_wr_en = 1'b0, list_clear = 1'b0;
    logic list_wr_en = 1'b0, continuous_mode = 1'b0, stop = 1'b0, trig_pin = 1'b0;
    logic [13:0] lut_wr_addr = 14'h0;
    logic [15:0] lut_wr_data = 16'h0, list_wr_ticks = 16'h0, even, odd, le, lo;
    logic [31:0] list_wr_word = 32'h0, frequency_control_word = 32'h0, pairs;
    logic [6:0] sync_duty = 7'h32;
    logic list_full, generating, dac_valid_q, sync_q;
    int error_cnt = 0, num_checks = 0, gen_cnt = 0, g0, p0, hi, pct;
    int duty[3] = '{10, 50, 90};
    always #20 clock = ~clock;
    always @(posedge clock) if (generating === 1'b1) gen_cnt++;
    dds_waveform_generator dut (.clock(clock), .rst_n(rst_n), .lut_wr_en(lut_wr_en),
        .lut_wr_addr(lut_wr_addr), .lut_wr_data(lut_wr_data), .list_clear(list_clear),
        .list_wr_en(list_wr_en), .list_wr_word(list_wr_word), .list_wr_ticks(list_wr_ticks),
        .list_full(list_full), .frequency_control_word(frequency_control_word),
        .continuous_mode(continuous_mode), .stop(stop), .trig_pin(trig_pin),
        .sync_duty(sync_duty), .generating(generating), .dac_even_q(even), .dac_odd_q(odd),
        .dac_valid_q(dac_valid_q), .sync_q(sync_q));
    dac_sink_model model (.clock(clock), .rst_n(rst_n), .even_in(even), .odd_in(odd),
        .valid_in(dac_valid_q), .pair_cnt_q(pairs), .last_even_q(le), .last_odd_q(lo));
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wait_gen(input int lim);
        int n;
        n = 0;
        while (generating !== 1'b1 && n < lim) begin
            @(negedge clock);
            n++;
        end
        if (n >= lim) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask : wait_gen
    task automatic trig_and_wait;
        trig_pin = 1'b1;
        repeat (2) @(negedge clock);
        trig_pin = 1'b0;
        wait_gen(10);
    endtask : trig_and_wait
    task automatic halt;
        stop = 1'b1;
        @(negedge clock);
        stop = 1'b0;
        `CHECK(generating, 1'b0)
    endtask : halt
    task automatic clear_list;
        list_clear = 1'b1;
        @(negedge clock);
        list_clear = 1'b0;
        `CHECK(list_full, 1'b0)
    endtask : clear_list
    task automatic add_entries(input int n, input logic [15:0] t);
        for (int i = 0; i < n; i++) begin
            if (i == 511) `CHECK(list_full, 1'b0)
            list_wr_en = 1'b1;
            list_wr_word = 32'h00040000;
            list_wr_ticks = t;
            @(negedge clock);
        end
        list_wr_en = 1'b0;
        @(negedge clock);
    endtask : add_entries
    task automatic t_load_and_free_run;
        for (int i = 0; i < 16384; i++) begin
            lut_wr_en = 1'b1;
            lut_wr_addr = i[13:0];
            lut_wr_data = i[15:0];
            @(negedge clock);
        end
        lut_wr_en = 1'b0;
        frequency_control_word = 32'h00040000;
        g0 = gen_cnt;
        p0 = pairs;
        trig_and_wait();
        repeat (40) @(negedge clock);
        `CHECK(16'(even - le), 16'h0001)
        `CHECK(lo, le)
        halt();
        repeat (40) @(negedge clock);
        `CHECK(pairs - p0, 32'(gen_cnt - g0))
    endtask : t_load_and_free_run
    task automatic t_list_fill;
        add_entries(512, 16'h0003);
        `CHECK(list_full, 1'b1)
        add_entries(1, 16'h0003);
        `CHECK(list_full, 1'b1)
        clear_list();
    endtask : t_list_fill
    task automatic t_list_modes;
        add_entries(2, 16'h0003);
        g0 = gen_cnt;
        trig_and_wait();
        repeat (40) @(negedge clock);
        `CHECK(generating, 1'b0)
        `CHECK(gen_cnt - g0, 8)
        continuous_mode = 1'b1;
        trig_and_wait();
        repeat (40) @(negedge clock);
        `CHECK(gen_cnt - g0 > 16, 1'b1)
        halt();
        clear_list();
    endtask : t_list_modes
    task automatic t_sync_duty;
        frequency_control_word = 32'h04000000;
        foreach (duty[k]) begin
            sync_duty = duty[k][6:0];
            pct = duty[k] < 20 ? 20 : duty[k] > 80 ? 80 : duty[k];
            trig_and_wait();
            hi = 0;
            repeat (32) @(negedge clock);
            repeat (64) begin
                @(negedge clock);
                hi += (sync_q === 1'b1);
            end
            `CHECK(hi >= 64 * pct / 100 && hi <= 64 * pct / 100 + 1, 1'b1)
            halt();
        end
    endtask : t_sync_duty
    initial begin
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        `CHECK({generating, dac_valid_q, list_full, sync_q}, 4'h0)
        t_load_and_free_run();
        t_list_fill();
        t_list_modes();
        t_sync_duty();
        tally_and_finish();
    end
endmodule : dds_waveform_generator_test
`default_nettype wire

/* File: rtl/dds_pkg.sv */
// Constants shared by the synthesis core and its memories.
// Assumes one clock that serves as the sample update clock.
package dds_pkg;
    // ****************
    // Widths and sizes
    // ****************
    localparam int ACC_W = 32;
    localparam int LUT_ADDR_W = 14;
    localparam int LUT_DEPTH = 16384;
    localparam int SAMPLE_W = 16;
    localparam int LIST_DEPTH = 512;
    localparam int LIST_ADDR_W = 9;
    localparam int LIST_CNT_W = 10;
    localparam int TICKS_W = 16;
    localparam int ENTRY_W = ACC_W + TICKS_W;
    localparam int COEF_W = 20;
    localparam int DUTY_W = 7;

    // ****************
    // Timing
    // ****************
    localparam real UPDATE_MHZ = 40.0;
    localparam int PIPE_LATENCY = 26;
    localparam int FILTER_STAGES = 4;
    localparam int PAD_STAGES = PIPE_LATENCY - FILTER_STAGES;

    // ****************
    // Filter and sync
    // ****************
    localparam logic signed [COEF_W-1:0] COEF_NEAR = 20'sh48000;
    localparam logic signed [COEF_W-1:0] COEF_FAR = 20'shf8000;
    localparam int COEF_SHIFT = 19;
    localparam logic [DUTY_W-1:0] DUTY_MIN = 7'h14;
    localparam logic [DUTY_W-1:0] DUTY_MAX = 7'h50;
    localparam logic [ACC_W-1:0] PHASE_PER_PCT = 32'h028f5c29;

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_LOAD, ST_RUN} gen_state_e;
endpackage : dds_pkg

/* File: rtl/dds_waveform_generator.sv */
// Phase accumulator, lookup memory, staging list, interpolating filter
// and sync generator of a single-channel synthesis path.
// Assumes the clock is the sample update clock; host ports are synchronous.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - 32-bit accumulator adds control word each tick
// - Update clock only internal, fixed rate
// - Lookup holds 16384 16-bit host-loaded samples
// - Fourteen accumulator bits address the lookup
// - Fixed 20-bit coefficient filter doubles rate
// - Path latency is 26 sample periods; generating to dac_valid_q takes 29 clocks here
// - Output within 28 clocks after trigger; valid rises 32 clocks after it, 34 with a list
// - Staging list holds 512 entries
// - Sync duty programmable 20 to 80 percent
// - Continuous repeats list, single runs once
module dds_waveform_generator (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Lookup memory load
    input wire logic lut_wr_en,
    input wire logic [dds_pkg::LUT_ADDR_W-1:0] lut_wr_addr,
    input wire logic [dds_pkg::SAMPLE_W-1:0] lut_wr_data,
    // Staging list load
    input wire logic list_clear,
    input wire logic list_wr_en,
    input wire logic [dds_pkg::ACC_W-1:0] list_wr_word,
    input wire logic [dds_pkg::TICKS_W-1:0] list_wr_ticks,
    output logic list_full,
    // Control
    input wire logic [dds_pkg::ACC_W-1:0] frequency_control_word,
    input wire logic continuous_mode,
    input wire logic stop,
    input wire logic trig_pin,
    input wire logic [dds_pkg::DUTY_W-1:0] sync_duty,
    output logic generating,
    // Converter side
    output logic [dds_pkg::SAMPLE_W-1:0] dac_even_q,
    output logic [dds_pkg::SAMPLE_W-1:0] dac_odd_q,
    output logic dac_valid_q,
    output logic sync_q
);
    // ****************
    // Declarations
    // ****************
    localparam int LINE_W = 2 * dds_pkg::SAMPLE_W + 2;

    dds_pkg::gen_state_e state_q;
    logic [dds_pkg::ACC_W-1:0] phase_q;
    logic [dds_pkg::ACC_W-1:0] word_q;
    logic [dds_pkg::TICKS_W-1:0] ticks_q;
    logic [dds_pkg::LIST_ADDR_W-1:0] rd_idx_q;
    logic [dds_pkg::LIST_CNT_W-1:0] list_len_q;
    logic trig_meta_q, trig_sync_q, trig_prev_q;
    logic trig_rise;
    logic [dds_pkg::SAMPLE_W-1:0] lut_rd;
    logic [dds_pkg::ENTRY_W-1:0] entry_rd;
    logic run_d1_q, run_d2_q, sync_d1_q, sync_d2_q;
    logic signed [dds_pkg::SAMPLE_W-1:0] tap_q [dds_pkg::FILTER_STAGES];
    logic [dds_pkg::FILTER_STAGES-1:0] tap_run_q, tap_sync_q;
    logic signed [dds_pkg::SAMPLE_W-1:0] odd_sample;
    logic [LINE_W-1:0] line_q [dds_pkg::PAD_STAGES];
    logic [dds_pkg::DUTY_W-1:0] duty_clamped;
    logic [dds_pkg::ACC_W-1:0] sync_threshold;
    logic last_entry;

    // Saturate a filter sum to sample width
    function automatic logic signed [dds_pkg::SAMPLE_W-1:0] saturate(
        input logic signed [dds_pkg::ACC_W+8-1:0] v);
        logic signed [dds_pkg::ACC_W+8-1:0] hi;
        logic signed [dds_pkg::ACC_W+8-1:0] lo;
        hi = (dds_pkg::ACC_W+8)'(16'sh7fff);
        lo = -(dds_pkg::ACC_W+8)'(16'sh7fff) - 1;
        if (v > hi) begin
            saturate = 16'sh7fff;
        end else if (v < lo) begin
            saturate = 16'sh8000;
        end else begin
            saturate = v[dds_pkg::SAMPLE_W-1:0];
        end
    endfunction : saturate

    // ****************
    // Trigger input
    // ****************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            trig_meta_q <= 1'b0;
            trig_sync_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end else begin
            trig_meta_q <= trig_pin;
            trig_sync_q <= trig_meta_q;
            trig_prev_q <= trig_sync_q;
        end
    end
    assign trig_rise = trig_sync_q && !trig_prev_q;

    // ****************
    // Staging list
    // ****************
    assign list_full = (list_len_q == dds_pkg::LIST_CNT_W'(dds_pkg::LIST_DEPTH));

    always_ff @(posedge clock) begin
        if (!rst_n || list_clear) begin
            list_len_q <= '0;
        end else if (list_wr_en && !list_full && state_q == dds_pkg::ST_IDLE) begin
            list_len_q <= list_len_q + 1'b1;
        end
    end

    sample_memory #(
        .WIDTH(dds_pkg::ENTRY_W),
        .DEPTH(dds_pkg::LIST_DEPTH),
        .AW(dds_pkg::LIST_ADDR_W)
    ) u_list (
        .clock(clock),
        .wr_en(list_wr_en && !list_full && state_q == dds_pkg::ST_IDLE),
        .wr_addr(list_len_q[dds_pkg::LIST_ADDR_W-1:0]),
        .wr_data({list_wr_word, list_wr_ticks}),
        .rd_addr(rd_idx_q),
        .rd_data_q(entry_rd)
    );

    // ****************
    // Sequencer
    // ****************
    assign last_entry = ({1'b0, rd_idx_q} + 1'b1) >= list_len_q;
    assign generating = (state_q == dds_pkg::ST_RUN);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= dds_pkg::ST_IDLE;
            rd_idx_q <= '0;
            ticks_q <= '0;
            word_q <= '0;
        end else begin
            unique case (state_q)
                dds_pkg::ST_IDLE: begin
                    rd_idx_q <= '0;
                    if (trig_rise && list_len_q == '0) begin
                        word_q <= frequency_control_word;
                        state_q <= dds_pkg::ST_RUN;
                    end else if (trig_rise) begin
                        state_q <= dds_pkg::ST_FETCH;
                    end
                end
                dds_pkg::ST_FETCH: begin
                    state_q <= stop ? dds_pkg::ST_IDLE : dds_pkg::ST_LOAD;
                end
                dds_pkg::ST_LOAD: begin
                    word_q <= entry_rd[dds_pkg::ENTRY_W-1:dds_pkg::TICKS_W];
                    ticks_q <= entry_rd[dds_pkg::TICKS_W-1:0];
                    state_q <= stop ? dds_pkg::ST_IDLE : dds_pkg::ST_RUN;
                end
                dds_pkg::ST_RUN: begin
                    if (stop) begin
                        state_q <= dds_pkg::ST_IDLE;
                    end else if (list_len_q == '0) begin
                        word_q <= frequency_control_word;
                    end else if (ticks_q != '0) begin
                        ticks_q <= ticks_q - 1'b1;
                    end else if (!last_entry) begin
                        rd_idx_q <= rd_idx_q + 1'b1;
                        state_q <= dds_pkg::ST_FETCH;
                    end else if (continuous_mode) begin
                        rd_idx_q <= '0;
                        state_q <= dds_pkg::ST_FETCH;
                    end else begin
                        state_q <= dds_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************
    // Phase accumulator
    // ****************
    always_ff @(posedge clock) begin
        if (!rst_n || state_q == dds_pkg::ST_IDLE) begin
            phase_q <= '0;
        end else if (state_q == dds_pkg::ST_RUN) begin
            phase_q <= phase_q + word_q;
        end
    end

    sample_memory #(
        .WIDTH(dds_pkg::SAMPLE_W),
        .DEPTH(dds_pkg::LUT_DEPTH),
        .AW(dds_pkg::LUT_ADDR_W)
    ) u_lut (
        .clock(clock),
        .wr_en(lut_wr_en),
        .wr_addr(lut_wr_addr),
        .wr_data(lut_wr_data),
        .rd_addr(phase_q[dds_pkg::ACC_W-1 -: dds_pkg::LUT_ADDR_W]),
        .rd_data_q(lut_rd)
    );

    // ****************
    // Sync output
    // ****************
    assign duty_clamped = (sync_duty < dds_pkg::DUTY_MIN) ? dds_pkg::DUTY_MIN :
                          (sync_duty > dds_pkg::DUTY_MAX) ? dds_pkg::DUTY_MAX : sync_duty;
    assign sync_threshold = dds_pkg::ACC_W'(duty_clamped * dds_pkg::PHASE_PER_PCT);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            run_d1_q <= 1'b0;
            run_d2_q <= 1'b0;
            sync_d1_q <= 1'b0;
            sync_d2_q <= 1'b0;
        end else begin
            run_d1_q <= generating;
            run_d2_q <= run_d1_q;
            sync_d1_q <= generating && (phase_q < sync_threshold);
            sync_d2_q <= sync_d1_q;
        end
    end

    // ****************
    // Interpolating filter
    // ****************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tap_run_q <= '0;
            tap_sync_q <= '0;
        end else begin
            tap_run_q <= {tap_run_q[2:0], run_d2_q};
            tap_sync_q <= {tap_sync_q[2:0], sync_d2_q};
        end
    end

    generate
        for (genvar i = 0; i < dds_pkg::FILTER_STAGES; i++) begin : g_tap
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    tap_q[i] <= '0;
                end else if (i == 0) begin
                    tap_q[i] <= run_d1_q ? signed'(lut_rd) : '0;
                end else begin
                    tap_q[i] <= tap_q[(i == 0) ? 0 : i-1];
                end
            end
        end
    endgenerate

    // Half-band midpoint between the two centre taps
    assign odd_sample = saturate(((dds_pkg::ACC_W+8)'(tap_q[1] + tap_q[2]) *
                                  dds_pkg::COEF_NEAR +
                                  (dds_pkg::ACC_W+8)'(tap_q[0] + tap_q[3]) *
                                  dds_pkg::COEF_FAR) >>> dds_pkg::COEF_SHIFT);

    // ****************
    // Latency padding
    // ****************
    generate
        for (genvar k = 0; k < dds_pkg::PAD_STAGES; k++) begin : g_pad
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    line_q[k] <= '0;
                end else if (k == 0) begin
                    line_q[k] <= {tap_run_q[3], tap_sync_q[3], tap_q[2], odd_sample};
                end else begin
                    line_q[k] <= line_q[(k == 0) ? 0 : k-1];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dac_even_q <= '0;
            dac_odd_q <= '0;
            dac_valid_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            {dac_valid_q, sync_q, dac_even_q, dac_odd_q} <= line_q[dds_pkg::PAD_STAGES-1];
        end
    end
endmodule : dds_waveform_generator
`default_nettype wire

/* File: rtl/sample_memory.sv */
// Single-port-write, registered-read memory.
// Assumes writer and reader share one clock.
`timescale 1ns/10ps
`default_nettype none
module sample_memory #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16384,
    parameter int AW = 14
) (
    // Clock
    input wire logic clock,
    // Write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // Read side
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data_q
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        rd_data_q <= mem[rd_addr];
    end
endmodule : sample_memory
`default_nettype wire
